/* File: plam_life_counter.sv */
`default_nettype none
module plam_life_counter import plam_pkg::*; #(
   parameter int STEP = 10000
) (
   input wire logic clk, // Device clock
   input wire logic nrst, // Synchronous reset, low active
   input wire logic ce, // Clock enable
   input wire logic tick, // One wear event
   output logic [7:0] pct // Remaining life in percent
);
   logic [15:0] cnt_q;
   logic [7:0] pct_q;

   // ==========================================================
   // Wear counting
   // percent step down
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cnt_q <= 16'h0000;
         pct_q <= PCT_FULL;
      end else if (ce && tick) begin
         if (cnt_q == 16'(STEP - 1)) begin
            cnt_q <= 16'h0000;
            // Floor at zero so an over-worn part never wraps back to full
            if (pct_q != 8'h00) begin
               pct_q <= pct_q - 8'h01;
            end
         end else begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end
   end

   assign pct = pct_q;

   // ==========================================================
   // Checks
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   step_down_a: assert property (
      ce && tick && cnt_q == 16'(STEP - 1) && pct_q != 8'h00 |=> pct_q == $past(pct_q) - 8'h01)
      else $error("life percent did not step down");
   no_early_a: assert property (
      ce && tick && cnt_q != 16'(STEP - 1) |=> pct_q == $past(pct_q))
      else $error("life percent moved before a full step");
endmodule
`default_nettype wire

/* File: plam_meas_partner.sv */
`default_nettype none
module plam_meas_partner (
   input wire logic clk, // Device clock
   input wire logic dcInject, // Injection from the block
   input wire logic relayTerminal, // Relay terminal, set to low active alarm
   input wire logic [1:0] mode, // 0 done, 1 fault, 2 abort, 3 silent
   input wire logic [3:0] dly, // Cycles of injection before the answer
   input wire logic [7:0] pct, // Result to report
   output logic measDone, // Result valid pulse
   output logic measFault, // Error pulse
   output logic measAbort, // Forced end pulse
   output logic [7:0] measPct, // Result, scrambled while not valid
   output logic alarmSeen // Controller view of the alarm terminal
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt;
   initial begin
      cnt = 4'h0;
      measDone = 1'b0;
      measFault = 1'b0;
      measAbort = 1'b0;
      measPct = 8'h00;
      alarmSeen = 1'b0;
   end
   // ==========================================================
   // Front end
   always @(posedge clk) begin
      measDone <= 1'b0;
      measFault <= 1'b0;
      measAbort <= 1'b0;
      // Stale result must not look valid
      measPct <= ~measPct;
      alarmSeen <= ~relayTerminal;
      cnt <= dcInject ? cnt + 4'h1 : 4'h0;
      if (dcInject && cnt == dly) begin
         measDone <= (mode == 2'h0);
         measFault <= (mode == 2'h1);
         measAbort <= (mode == 2'h2);
         measPct <= pct;
      end
   end
endmodule
`default_nettype wire

/* File: plam_monitor.sv */
//
// Summary of operation
// - Keep a four-bit life status, one bit per part at alarm level.
// - Combined life alarm is the OR of the four status bits.
// - Function code 90 drives alarm high active, 190 low active on a terminal.
// - Inrush life drops one percent per ten thousand activations from 100.
// - Inrush life at 10 percent sets status bit 3.
// - Power-on, undervoltage and drive reset each count one inrush activation; here events in the same cycle count once together.
// - Control capacitor life counts down while operating by weighted aging.
// - Control capacitor life below 10 percent sets status bit 0.
// - Main capacitor life updates after each completed measurement.
// - Measured main capacitor life at or below 85 sets status bit 1.
// - Control resets to 0; writing 1 arms measurement at next power-off.
// - Codes 2 running, 3 done, 8 forced end, 9 error; 3 and 8 unwritable.
// - Motor must be connected and stopped; DC injection measures at power-off.
// - Violated conditions end forced, in error, or leave measurement armed.
// - Early power return may leave code 2; rewriting 1 restarts.
// - Fan at or below half speed sets status bit 2.
//
// Chosen here: strobed register access and the placing of the registers.
`default_nettype none
module plam_monitor import plam_pkg::*; #(
   parameter int INRUSH_STEP_P = INRUSH_STEP,
   parameter int CTRL_STEP_P = CTRL_STEP
) (
   input wire logic clk, // Device clock, 40 MHz
   input wire logic nrst, // Synchronous reset, low active
   input wire logic ce, // Clock enable, freezes all state when low
   input wire logic [3:0] regAddr, // Register index
   input wire logic [7:0] regWdata, // Write data
   input wire logic regWr, // Write strobe
   input wire logic regRd, // Read strobe
   output logic [7:0] regRdata, // Read data, cycle after strobe
   input wire logic powerOnEvt, // Power-on pulse
   input wire logic undervoltEvt, // Undervoltage pulse
   input wire logic driveResetEvt, // Drive unit reset pulse
   input wire logic operating, // Unit energized and running
   input wire logic ctrlAgeTick, // Weighted aging tick for control cap
   input wire logic fanSlow, // Fan at or below half speed
   input wire logic powerOff, // Mains removed level
   input wire logic measDone, // Capacitance result valid pulse
   input wire logic [7:0] measPct, // Measured capacitance percent
   input wire logic measAbort, // Start, shutoff or coasting seen
   input wire logic measFault, // Trip or bad measurement
   output logic dcInject, // DC injection into motor
   output logic lifeAlarmOut, // Combined life alarm
   output logic runTerminal, // Run terminal level
   output logic relayTerminal, // Relay terminal level
   output logic irq // Interrupt, high level
);
   logic [7:0] inrushPct;
   logic [7:0] ctrlPct;
   logic [7:0] mainPct_q;
   logic mainMeasured_q;
   logic [3:0] lifeStatus;
   logic [3:0] measCode_q;
   plam_meas_t measState_q;
   logic powerOff_q;
   logic powerOffRise;
   logic measEnd;
   logic inrushTick;
   logic lifeAlarm_q;
   logic runTerm_q;
   logic relayTerm_q;
   logic [7:0] runSel_q;
   logic [7:0] relaySel_q;
   logic [1:0] irqStat_q;
   logic [1:0] irqMask_q;
   logic [1:0] irqEvt;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic measWr;

   // ==========================================================
   // Wear counters
   // inrush activation sources
   assign inrushTick = powerOnEvt | undervoltEvt | driveResetEvt;

   plam_life_counter #(.STEP(INRUSH_STEP_P)) inrushCnt (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .tick(inrushTick),
      .pct(inrushPct)
   );

   plam_life_counter #(.STEP(CTRL_STEP_P)) ctrlCnt (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .tick(operating & ctrlAgeTick),
      .pct(ctrlPct)
   );

   // ==========================================================
   // Life status, combinational so it moves with the life value
   // status decode
   always_comb begin
      lifeStatus = 4'h0;
      lifeStatus[BIT_CTRL_CAP] = ctrlPct < CTRL_ALARM_PCT;
      // main cap, only once a measurement has been made
      lifeStatus[BIT_MAIN_CAP] = mainMeasured_q && (mainPct_q <= MAIN_ALARM_PCT);
      lifeStatus[BIT_FAN] = fanSlow;
      lifeStatus[BIT_INRUSH] = inrushPct <= INRUSH_ALARM_PCT;
   end

   // ==========================================================
   // Alarm and terminal outputs
   // registered alarm routing
   always_ff @(posedge clk) begin
      if (!nrst) begin
         lifeAlarm_q <= 1'b0;
         runTerm_q <= 1'b0;
         relayTerm_q <= 1'b0;
      end else if (ce) begin
         lifeAlarm_q <= |lifeStatus;
         // Terminals with other functions are left inactive here
         runTerm_q <= (runSel_q == FUNC_ALARM_POS) ? (|lifeStatus) :
                      (runSel_q == FUNC_ALARM_NEG) ? !(|lifeStatus) : 1'b0;
         relayTerm_q <= (relaySel_q == FUNC_ALARM_POS) ? (|lifeStatus) :
                        (relaySel_q == FUNC_ALARM_NEG) ? !(|lifeStatus) : 1'b0;
      end
   end

   assign lifeAlarmOut = lifeAlarm_q;
   assign runTerminal = runTerm_q;
   assign relayTerminal = relayTerm_q;

   // ==========================================================
   // Main capacitor measurement
   assign measWr = regWr && (regAddr == ADDR_MEAS_CTRL);
   assign powerOffRise = powerOff && !powerOff_q;
   assign measEnd = (measState_q == MS_MEASURE) && (measDone || measFault || measAbort);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         powerOff_q <= 1'b0;
      end else if (ce) begin
         powerOff_q <= powerOff;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         measState_q <= MS_IDLE;
         measCode_q <= MC_IDLE;
      end else if (ce) begin
         if (measWr && regWdata == {4'h0, MC_ARM}) begin
            // Rearm from any state, also from a stuck code 2
            measState_q <= MS_ARMED;
            measCode_q <= MC_ARM;
         end else if (measWr && regWdata == {4'h0, MC_IDLE}) begin
            measState_q <= MS_IDLE;
            measCode_q <= MC_IDLE;
         end else begin
            case (measState_q)
               MS_ARMED: begin
                  if (powerOffRise) begin
                     measState_q <= MS_MEASURE;
                     measCode_q <= MC_RUN;
                  end
               end
               MS_MEASURE: begin
                  // Power returning early is not an end: code 2 stays
                  if (measDone) begin
                     measState_q <= MS_IDLE;
                     measCode_q <= MC_DONE;
                  end else if (measFault) begin
                     measState_q <= MS_IDLE;
                     measCode_q <= MC_ERROR;
                  end else if (measAbort) begin
                     measState_q <= MS_IDLE;
                     measCode_q <= MC_FORCED;
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // main cap result, untouched by power events
   always_ff @(posedge clk) begin
      if (!nrst) begin
         mainPct_q <= PCT_FULL;
         mainMeasured_q <= 1'b0;
      end else if (ce && measState_q == MS_MEASURE && measDone && !measWr) begin
         mainPct_q <= measPct;
         mainMeasured_q <= 1'b1;
      end
   end

   assign dcInject = (measState_q == MS_MEASURE);

   // ==========================================================
   // Software settings
   always_ff @(posedge clk) begin
      if (!nrst) begin
         runSel_q <= TERM_SEL_RST;
         relaySel_q <= TERM_SEL_RST;
         irqMask_q <= IRQ_MASK_RST;
      end else if (ce && regWr) begin
         case (regAddr)
            ADDR_RUN_SEL: runSel_q <= regWdata;
            ADDR_RELAY_SEL: relaySel_q <= regWdata;
            ADDR_IRQ_MASK: irqMask_q <= regWdata[1:0];
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // Interrupts: read clears, a new event in the same cycle wins
   always_comb begin
      irqEvt = 2'h0;
      irqEvt[IRQ_ALARM] = (|lifeStatus) && !lifeAlarm_q;
      irqEvt[IRQ_MEAS] = measEnd && !measWr;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         irqStat_q <= 2'h0;
      end else if (ce) begin
         if (regRd && regAddr == ADDR_IRQ_STATUS) begin
            irqStat_q <= irqEvt;
         end else begin
            irqStat_q <= irqStat_q | irqEvt;
         end
      end
   end

   assign irq = |(irqStat_q & irqMask_q);

   // ==========================================================
   // Read port, unmapped indices read as zero
   always_comb begin
      case (regAddr)
         ADDR_STATUS: rdata_d = {4'h0, lifeStatus};
         ADDR_INRUSH: rdata_d = inrushPct;
         ADDR_CTRL_CAP: rdata_d = ctrlPct;
         ADDR_MAIN_CAP: rdata_d = mainPct_q;
         ADDR_MEAS_CTRL: rdata_d = {4'h0, measCode_q};
         ADDR_RUN_SEL: rdata_d = runSel_q;
         ADDR_RELAY_SEL: rdata_d = relaySel_q;
         ADDR_IRQ_STATUS: rdata_d = {6'h00, irqStat_q};
         ADDR_IRQ_MASK: rdata_d = {6'h00, irqMask_q};
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdata_q <= 8'h00;
      end else if (ce) begin
         rdata_q <= regRd ? rdata_d : 8'h00;
      end
   end

   assign regRdata = rdata_q;

   // ==========================================================
   // Checks
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence armedOff_s;
      ce && measState_q == MS_ARMED && powerOffRise && !measWr;
   endsequence

   sequence measuring_s;
      measCode_q == MC_RUN && dcInject;
   endsequence

   sequence powerBack_s;
      ce && measState_q == MS_MEASURE && !powerOff && !measWr
      && !measDone && !measFault && !measAbort;
   endsequence

   alarm_follow_a: assert property (
      ce |=> lifeAlarmOut == $past(|lifeStatus))
      else $error("alarm output does not follow status OR");
   term_neg_a: assert property (
      ce && !regWr && relaySel_q == FUNC_ALARM_NEG |=> relayTerminal == !$past(|lifeStatus))
      else $error("low active terminal wrong");
   term_pos_a: assert property (
      ce && runSel_q == FUNC_ALARM_POS |=> runTerminal == $past(|lifeStatus))
      else $error("high active terminal wrong");
   inrush_bit_a: assert property (
      $fell(inrushPct > INRUSH_ALARM_PCT) |-> lifeStatus[BIT_INRUSH] ##1 lifeAlarmOut || !$past(ce))
      else $error("inrush alarm not raised at threshold");
   ctrl_bit_a: assert property (
      $fell(ctrlPct >= CTRL_ALARM_PCT) |-> lifeStatus[BIT_CTRL_CAP] ##1 lifeAlarmOut || !$past(ce))
      else $error("control cap alarm not raised below threshold");
   meas_start_a: assert property (
      armedOff_s |=> measuring_s)
      else $error("measurement did not start at power-off");
   meas_done_a: assert property (
      ce && measState_q == MS_MEASURE && measDone && !measWr
      |=> measCode_q == MC_DONE && mainPct_q == $past(measPct))
      else $error("measurement result not stored");
   main_bit_a: assert property (
      ce && measState_q == MS_MEASURE && measDone && !measWr && measPct <= 8'h55
      |=> lifeStatus[BIT_MAIN_CAP] ##1 lifeAlarmOut || !$past(ce))
      else $error("main cap alarm missing");
   forced_end_a: assert property (
      ce && measState_q == MS_MEASURE && measAbort && !measDone && !measFault && !measWr
      |=> measCode_q == MC_FORCED && !dcInject)
      else $error("forced end code missing");
   rearm_a: assert property (
      ce && measWr && regWdata == 8'h01 |=> measCode_q == MC_ARM && measState_q == MS_ARMED)
      else $error("rewrite of arm code ignored");
   fan_bit_a: assert property (
      ce && fanSlow |=> lifeAlarmOut)
      else $error("fan alarm missing");
   keep_life_a: assert property (
      ce && (powerOnEvt || powerOffRise) && measState_q != MS_MEASURE && !measWr
      |=> $stable(mainPct_q) && $stable(mainMeasured_q))
      else $error("power event disturbed main cap life");
   status_read_a: assert property (
      ce && regRd && regAddr == ADDR_STATUS |=> regRdata == {4'h0, $past(lifeStatus)})
      else $error("status read does not match status bits");
   meas_error_a: assert property (
      ce && measState_q == MS_MEASURE && measFault && !measDone && !measWr
      |=> measCode_q == MC_ERROR && !dcInject)
      else $error("error code missing");
   // Only 0 and 1 are accepted, result codes stay display only
   ro_code_a: assert property (
      ce && measState_q == MS_IDLE && measWr && regWdata != 8'h00 && regWdata != 8'h01
      |=> $stable(measCode_q))
      else $error("display only code was written");
   power_hold_a: assert property (
      powerBack_s |=> measuring_s)
      else $error("early power return left the running code");
endmodule
`default_nettype wire

/* File: plam_monitor_bench.sv */
`default_nettype none
module plam_monitor_bench import plam_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWdata = 8'h00;
   logic regWr = 1'b0, regRd = 1'b0;
   logic powerOnEvt = 1'b0, undervoltEvt = 1'b0, driveResetEvt = 1'b0;
   logic operating = 1'b0, ctrlAgeTick = 1'b0, fanSlow = 1'b0, powerOff = 1'b0;
   logic [1:0] pMode = 2'h0;
   logic [3:0] pDly = 4'h0;
   logic [7:0] pPct = 8'h00;
   logic measDone, measFault, measAbort, dcInject, lifeAlarmOut;
   logic runTerminal, relayTerminal, irq, alarmSeen;
   logic [7:0] measPct, regRdata;
   int fail_count = 0;
   int compares = 0;
   always #12.5 clk = ~clk;
   // Short steps keep the wear scenarios to a few hundred cycles
   plam_monitor #(.INRUSH_STEP_P(4), .CTRL_STEP_P(2)) i_dut (.clk(clk), .nrst(nrst), .ce(ce),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .powerOnEvt(powerOnEvt), .undervoltEvt(undervoltEvt),
      .driveResetEvt(driveResetEvt), .operating(operating), .ctrlAgeTick(ctrlAgeTick),
      .fanSlow(fanSlow), .powerOff(powerOff), .measDone(measDone), .measPct(measPct),
      .measAbort(measAbort), .measFault(measFault), .dcInject(dcInject),
      .lifeAlarmOut(lifeAlarmOut), .runTerminal(runTerminal), .relayTerminal(relayTerminal),
      .irq(irq));
   plam_meas_partner i_partner (.clk(clk), .dcInject(dcInject), .relayTerminal(relayTerminal),
      .mode(pMode), .dly(pDly), .pct(pPct), .measDone(measDone), .measFault(measFault),
      .measAbort(measAbort), .measPct(measPct), .alarmSeen(alarmSeen));
   // ==========================================================
   // Helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      chk(regRdata, exp);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      rd(ADDR_STATUS, 8'h00);
      rd(ADDR_INRUSH, PCT_FULL);
      rd(ADDR_CTRL_CAP, PCT_FULL);
      rd(ADDR_MAIN_CAP, PCT_FULL);
      rd(ADDR_MEAS_CTRL, {4'h0, MC_IDLE});
      rd(4'hf, 8'h00);
      chk({7'h00, lifeAlarmOut}, 8'h00);
   endtask
   task automatic t_alarm();
      wr(ADDR_RUN_SEL, FUNC_ALARM_POS);
      wr(ADDR_RELAY_SEL, FUNC_ALARM_NEG);
      rd(ADDR_RELAY_SEL, FUNC_ALARM_NEG);
      // A write while the clock enable is low must be lost
      @(posedge clk);
      ce <= 1'b0;
      wr(ADDR_RUN_SEL, 8'h00);
      ce <= 1'b1;
      rd(ADDR_RUN_SEL, FUNC_ALARM_POS);
      wr(ADDR_IRQ_MASK, 8'h01);
      cyc(1);
      chk({6'h00, runTerminal, relayTerminal}, 8'h01);
      @(posedge clk);
      fanSlow <= 1'b1;
      #1;
      chk({7'h00, lifeAlarmOut}, 8'h00);
      cyc(1);
      chk({7'h00, lifeAlarmOut}, 8'h01);
      chk({6'h00, runTerminal, relayTerminal}, 8'h02);
      cyc(2);
      chk({6'h00, alarmSeen, irq}, 8'h03);
      rd(ADDR_STATUS, 8'h04);
      rd(ADDR_IRQ_STATUS, 8'h01);
      cyc(1);
      chk({7'h00, irq}, 8'h00);
      @(posedge clk);
      fanSlow <= 1'b0;
      cyc(2);
      chk({5'h00, lifeAlarmOut, runTerminal, relayTerminal}, 8'h01);
      wr(ADDR_IRQ_MASK, 8'h00);
      wr(ADDR_MEAS_CTRL, {4'h0, MC_DONE});
      wr(ADDR_MEAS_CTRL, {4'h0, MC_FORCED});
      rd(ADDR_MEAS_CTRL, {4'h0, MC_IDLE});
   endtask
   task automatic t_meas(input logic [1:0] mode, input logic [3:0] dly, input logic [7:0] pct,
      input logic [3:0] code, input logic [7:0] mainPct, input logic [7:0] stat);
      int i;
      // A stuck run keeps injecting, so the new answer is set only once rearmed
      wr(ADDR_MEAS_CTRL, {4'h0, MC_ARM});
      pMode <= mode;
      pDly <= dly;
      pPct <= pct;
      rd(ADDR_MEAS_CTRL, {4'h0, MC_ARM});
      @(posedge clk);
      powerOff <= 1'b1;
      cyc(2);
      chk({7'h00, dcInject}, 8'h01);
      for (i = 0; i < 30 && dcInject === 1'b1; i++) cyc(1);
      chk({7'h00, dcInject}, {7'h00, mode == 2'h3});
      @(posedge clk);
      powerOff <= 1'b0;
      rd(ADDR_MEAS_CTRL, {4'h0, code});
      rd(ADDR_MAIN_CAP, mainPct);
      rd(ADDR_STATUS, stat);
   endtask
   task automatic ev(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         powerOnEvt <= (i % 3 == 0);
         undervoltEvt <= (i % 3 == 1);
         driveResetEvt <= (i % 3 == 2);
      end
      @(posedge clk);
      {powerOnEvt, undervoltEvt, driveResetEvt} <= 3'h0;
      cyc(2);
   endtask
   task automatic t_inrush();
      @(posedge clk);
      {powerOnEvt, undervoltEvt, driveResetEvt} <= 3'h7;
      ev(3);
      rd(ADDR_INRUSH, 8'h63);
      ev(352);
      rd(ADDR_INRUSH, 8'h0b);
      rd(ADDR_STATUS, 8'h02);
      ev(4);
      rd(ADDR_INRUSH, INRUSH_ALARM_PCT);
      rd(ADDR_STATUS, 8'h0a);
   endtask
   task automatic tk(input int n, input logic op);
      repeat (n) begin
         @(posedge clk);
         operating <= op;
         ctrlAgeTick <= 1'b1;
         @(posedge clk);
         ctrlAgeTick <= 1'b0;
      end
      cyc(2);
   endtask
   task automatic t_ctrl();
      tk(5, 1'b0);
      rd(ADDR_CTRL_CAP, PCT_FULL);
      tk(180, 1'b1);
      rd(ADDR_CTRL_CAP, CTRL_ALARM_PCT);
      rd(ADDR_STATUS, 8'h0a);
      tk(2, 1'b1);
      rd(ADDR_CTRL_CAP, 8'h09);
      rd(ADDR_STATUS, 8'h0b);
      chk({7'h00, lifeAlarmOut}, 8'h01);
   endtask
   // ==========================================================
   // Run control
   task automatic final_report();
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_alarm();
      wr(ADDR_IRQ_MASK, 8'h02);
      t_meas(2'h0, 4'h0, 8'h56, MC_DONE, 8'h56, 8'h00);
      chk({7'h00, irq}, 8'h01);
      rd(ADDR_IRQ_STATUS, 8'h02);
      t_meas(2'h0, 4'h9, MAIN_ALARM_PCT, MC_DONE, MAIN_ALARM_PCT, 8'h02);
      t_meas(2'h1, 4'h2, 8'h32, MC_ERROR, MAIN_ALARM_PCT, 8'h02);
      t_meas(2'h2, 4'h0, 8'h32, MC_FORCED, MAIN_ALARM_PCT, 8'h02);
      t_meas(2'h3, 4'h0, 8'h32, MC_RUN, MAIN_ALARM_PCT, 8'h02);
      t_meas(2'h0, 4'h1, 8'h50, MC_DONE, 8'h50, 8'h02);
      wr(ADDR_IRQ_MASK, 8'h00);
      t_inrush();
      t_ctrl();
      final_report();
   end
   // Whole run needs about a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      final_report();
   end
endmodule
`default_nettype wire

/* File: plam_pkg.sv */
`default_nettype none
package plam_pkg;
   // ==========================================================
   // Register indices on the plain register port
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_INRUSH = 4'h1;
   localparam logic [3:0] ADDR_CTRL_CAP = 4'h2;
   localparam logic [3:0] ADDR_MAIN_CAP = 4'h3;
   localparam logic [3:0] ADDR_MEAS_CTRL = 4'h4;
   localparam logic [3:0] ADDR_RUN_SEL = 4'h5;
   localparam logic [3:0] ADDR_RELAY_SEL = 4'h6;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h7;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;

   // ==========================================================
   // Life alarm status bit positions
   localparam int BIT_CTRL_CAP = 0;
   localparam int BIT_MAIN_CAP = 1;
   localparam int BIT_FAN = 2;
   localparam int BIT_INRUSH = 3;

   // ==========================================================
   // Life percentages and thresholds
   localparam logic [7:0] PCT_FULL = 8'h64;
   localparam logic [7:0] INRUSH_ALARM_PCT = 8'h0a;
   localparam logic [7:0] CTRL_ALARM_PCT = 8'h0a;
   localparam logic [7:0] MAIN_ALARM_PCT = 8'h55;
   localparam int INRUSH_STEP = 10000;
   localparam int CTRL_STEP = 10000;

   // ==========================================================
   // Measurement control codes
   localparam logic [3:0] MC_IDLE = 4'h0;
   localparam logic [3:0] MC_ARM = 4'h1;
   localparam logic [3:0] MC_RUN = 4'h2;
   localparam logic [3:0] MC_DONE = 4'h3;
   localparam logic [3:0] MC_FORCED = 4'h8;
   localparam logic [3:0] MC_ERROR = 4'h9;

   // ==========================================================
   // Terminal function codes and reset values
   localparam logic [7:0] FUNC_ALARM_POS = 8'h5a;
   localparam logic [7:0] FUNC_ALARM_NEG = 8'hbe;
   localparam logic [7:0] TERM_SEL_RST = 8'h00;
   localparam logic [1:0] IRQ_MASK_RST = 2'h0;
   localparam int IRQ_ALARM = 0;
   localparam int IRQ_MEAS = 1;

   typedef enum logic [1:0] {MS_IDLE, MS_ARMED, MS_MEASURE} plam_meas_t;
endpackage
`default_nettype wire
